/* include/qcc_pkg.sv */
// shared constants, field layout and types of the quick charge controller
package qcc_pkg;

  // ==========================================================================
  // clock and time base
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CYC_PER_MS    = CLK_HZ / 1000;
  localparam int unsigned SAMPLE_MS     = 2340;
  localparam int unsigned SAMPLE_CYC    = CYC_PER_MS * SAMPLE_MS;
  localparam int unsigned LAMP_HALF_MS  = 500;
  localparam int unsigned LAMP_HALF_CYC = CYC_PER_MS * LAMP_HALF_MS;
  localparam int unsigned RESUME_MS     = 2300;
  localparam int unsigned RESUME_CYC    = CYC_PER_MS * RESUME_MS;

  // ==========================================================================
  // charge timers, counted in whole seconds
  localparam int unsigned SEC_W         = 14;
  localparam int unsigned PROHIBIT_MIN  = 15;
  localparam int unsigned PROHIBIT_S    = PROHIBIT_MIN * 60;
  localparam int unsigned MAX_HI_MIN    = 240;
  localparam int unsigned MAX_MID_MIN   = 120;
  localparam int unsigned MAX_LO_MIN    = 80;

  // ==========================================================================
  // converter result, 1 mV per lsb
  localparam int unsigned V_W           = 12;
  localparam int unsigned AVG_N         = 8;
  localparam int unsigned AVG_SHIFT     = 3;
  localparam int unsigned DV_MV         = 4;
  localparam int unsigned DET_LO_MV     = 1000;
  localparam int unsigned DET_HI_MV     = 2000;

  // ==========================================================================
  // decoded timer select
  localparam logic [1:0]  TSEL_LO       = 2'h0;
  localparam logic [1:0]  TSEL_MID      = 2'h1;
  localparam logic [1:0]  TSEL_HI       = 2'h2;

  // ==========================================================================
  // register map
  localparam int unsigned ADDR_W        = 4;
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_STAT      = 4'h4;
  localparam logic [3:0]  REG_PEAK      = 4'h8;
  localparam logic [3:0]  REG_TIME      = 4'hc;
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_RST_BIT  = 1;
  localparam logic        CTRL_EN_RST   = 1'h1;
  localparam int unsigned STAT_ST_LSB   = 0;
  localparam int unsigned STAT_HOLD_BIT = 4;
  localparam int unsigned STAT_FLT_BIT  = 5;
  localparam int unsigned STAT_ARM_BIT  = 6;
  localparam int unsigned STAT_SEL_LSB  = 8;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    QCC_INIT    = 3'b000,
    QCC_QUICK   = 3'b001,
    QCC_HOLD    = 3'b010,
    QCC_RESUME  = 3'b011,
    QCC_INHIBIT = 3'b100,
    QCC_FINISH  = 3'b101,
    QCC_STANDBY = 3'b110
  } qcc_state_type;

  // the unused select code falls back to the shortest limit, the safe side
  function automatic logic [SEC_W-1:0] qcc_max_limit(input logic [1:0] sel);
    unique case (sel)
      TSEL_HI:  qcc_max_limit = SEC_W'(MAX_HI_MIN * 60);
      TSEL_MID: qcc_max_limit = SEC_W'(MAX_MID_MIN * 60);
      default:  qcc_max_limit = SEC_W'(MAX_LO_MIN * 60);
    endcase
  endfunction : qcc_max_limit

endpackage : qcc_pkg

/* rtl/qcc_timebase.sv */
// clock divider giving lamp half-period, second and sample enables
`timescale 1ns/100ps
module qcc_timebase
  import qcc_pkg::*;
#(
  parameter int unsigned HALF_CYCLES   = LAMP_HALF_CYC,
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC
) (
  input  wire logic clock,
  input  wire logic rst_n,
  output logic      sec_tick,
  output logic      sample_tick,
  output logic      lamp_phase_ff
);

  localparam int unsigned HW = $clog2(HALF_CYCLES);
  localparam int unsigned SW = $clog2(SAMPLE_CYCLES);
  localparam logic [HW-1:0] HALF_LAST   = HW'(HALF_CYCLES - 1);
  localparam logic [SW-1:0] SAMPLE_LAST = SW'(SAMPLE_CYCLES - 1);

  logic [HW-1:0] half_cnt_ff;
  logic [SW-1:0] smp_cnt_ff;
  logic          half_tick;

  assign half_tick   = (half_cnt_ff == HALF_LAST);
  assign sample_tick = (smp_cnt_ff == SAMPLE_LAST);
  // a full second passes every second half period
  assign sec_tick    = half_tick & lamp_phase_ff;

  // ==========================================================================
  // lamp half period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt_ff   <= '0;
      lamp_phase_ff <= 1'b0;
    end else if (half_tick) begin
      half_cnt_ff   <= '0;
      lamp_phase_ff <= ~lamp_phase_ff;
    end else begin
      half_cnt_ff   <= half_cnt_ff + 1'b1;
    end
  end

  // ==========================================================================
  // conversion sample period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      smp_cnt_ff <= '0;
    end else if (sample_tick) begin
      smp_cnt_ff <= '0;
    end else begin
      smp_cnt_ff <= smp_cnt_ff + 1'b1;
    end
  end

endmodule : qcc_timebase

/* rtl/qcc_average.sv */
// mean of each block of eight consecutive converter samples
`timescale 1ns/100ps
module qcc_average
  import qcc_pkg::*;
#(
  parameter int unsigned WIDTH = V_W
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             clr,
  input  wire logic             sample_vld,
  input  wire logic [WIDTH-1:0] sample,
  output logic                  avg_vld_ff,
  output logic [WIDTH-1:0]      avg_ff
);

  localparam int unsigned SUM_W = WIDTH + AVG_SHIFT;

  logic [SUM_W-1:0]     sum_ff;
  logic [AVG_SHIFT-1:0] cnt_ff;
  logic [SUM_W-1:0]     nxt_sum;

  assign nxt_sum = sum_ff + SUM_W'(sample);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sum_ff     <= '0;
      cnt_ff     <= '0;
      avg_vld_ff <= 1'b0;
      avg_ff     <= '0;
    end else if (clr) begin
      // a partial block is dropped so no mean mixes hold and charge samples
      sum_ff     <= '0;
      cnt_ff     <= '0;
      avg_vld_ff <= 1'b0;
    end else begin
      avg_vld_ff <= 1'b0;
      if (sample_vld) begin
        cnt_ff <= cnt_ff + 1'b1;
        if (cnt_ff == AVG_SHIFT'(AVG_N - 1)) begin
          sum_ff     <= '0;
          avg_ff     <= nxt_sum[SUM_W-1:AVG_SHIFT];
          avg_vld_ff <= 1'b1;
        end else begin
          sum_ff <= nxt_sum;
        end
      end
    end
  end

endmodule : qcc_average

/* rtl/qcc_core.sv */
// quick charge controller core: sequencer, timers, delta detect, bus slave
//
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module qcc_core
  import qcc_pkg::*;
#(
  parameter int unsigned VW            = V_W,
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
  parameter int unsigned HALF_CYCLES   = LAMP_HALF_CYC,
  parameter int unsigned RESUME_CYCLES = RESUME_CYC
) (
  input  wire logic              clock,
  input  wire logic              reset_n,
  input  wire logic [VW-1:0]     cell_voltage_in,
  input  wire logic              window_fault_in,
  input  wire logic              above_standby_threshold_in,
  input  wire logic              charge_hold_in,
  input  wire logic [1:0]        timer_select_in,
  output logic                   charge_switch_n_o,
  output logic                   charge_switch_n_oe_n,
  output logic                   status_lamp_n_o,
  output logic                   status_lamp_n_oe_n,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  localparam int unsigned RW = $clog2(RESUME_CYCLES);
  localparam logic [RW-1:0]    RESUME_LAST = RW'(RESUME_CYCLES - 1);
  localparam logic [SEC_W-1:0] PROHIBIT_LIM = SEC_W'(PROHIBIT_S);
  localparam logic [VW:0]      DV_STEP   = (VW + 1)'(DV_MV);
  localparam logic [VW-1:0]    DET_LO    = VW'(DET_LO_MV);
  localparam logic [VW-1:0]    DET_HI    = VW'(DET_HI_MV);

  // ==========================================================================
  // reset release
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ==========================================================================
  // declarations
  qcc_state_type    state_ff;
  qcc_state_type    nxt_state;
  qcc_state_type    prev_ff;
  qcc_state_type    nxt_prev;
  logic [RW-1:0]    resume_cnt_ff;
  logic [SEC_W-1:0] elapsed_ff;
  logic [VW-1:0]    peak_ff;
  logic [VW-1:0]    avg;
  logic [1:0]       sel_ff;
  logic             enable_ff;
  logic             restart_ff;
  logic             sec_tick;
  logic             sample_tick;
  logic             lamp_phase;
  logic             avg_vld;
  logic             stop_req;
  logic             armed;
  logic             max_hit;
  logic             ndv_hit;
  logic             done;
  logic             peak_clr;
  logic             resume_done;

  // ==========================================================================
  // time base and averaging
  qcc_timebase #(
    .HALF_CYCLES   (HALF_CYCLES),
    .SAMPLE_CYCLES (SAMPLE_CYCLES)
  ) u_timebase (
    .clock         (clock),
    .rst_n         (rst_n),
    .sec_tick      (sec_tick),
    .sample_tick   (sample_tick),
    .lamp_phase_ff (lamp_phase)
  );

  // samples only count while quick charging, so a mean never spans a pause
  qcc_average #(
    .WIDTH      (VW)
  ) u_average (
    .clock      (clock),
    .rst_n      (rst_n),
    .clr        (state_ff != QCC_QUICK),
    .sample_vld (sample_tick),
    .sample     (cell_voltage_in),
    .avg_vld_ff (avg_vld),
    .avg_ff     (avg)
  );

  // ==========================================================================
  // termination conditions
  assign stop_req    = charge_hold_in | ~enable_ff;
  assign armed       = (elapsed_ff >= PROHIBIT_LIM);
  assign max_hit     = (elapsed_ff >= qcc_max_limit(sel_ff));
  assign ndv_hit     = avg_vld & armed & (avg > DET_LO) & (avg < DET_HI)
                     & ({1'b0, peak_ff} >= ({1'b0, avg} + DV_STEP));
  assign done        = ndv_hit | max_hit;
  assign resume_done = (resume_cnt_ff == RESUME_LAST);

  // ==========================================================================
  // sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_prev  = prev_ff;
    peak_clr  = 1'b0;
    if (restart_ff) begin
      nxt_state = QCC_INIT;
    end else if (above_standby_threshold_in && state_ff != QCC_STANDBY) begin
      nxt_state = QCC_STANDBY;
    end else begin
      unique case (state_ff)
        QCC_INIT: begin
          if (window_fault_in) begin
            nxt_state = QCC_HOLD;
          end else begin
            nxt_state = QCC_QUICK;
            peak_clr  = 1'b1;
          end
        end
        QCC_QUICK: begin
          if (stop_req) begin
            nxt_state = QCC_INHIBIT;
            nxt_prev  = QCC_QUICK;
          end else if (window_fault_in) begin
            nxt_state = QCC_HOLD;
          end else if (done) begin
            nxt_state = QCC_FINISH;
          end
        end
        QCC_HOLD: begin
          if (stop_req) begin
            nxt_state = QCC_INHIBIT;
            nxt_prev  = QCC_HOLD;
          end else if (!window_fault_in) begin
            nxt_state = QCC_RESUME;
          end
        end
        QCC_RESUME: begin
          if (stop_req) begin
            nxt_state = QCC_INHIBIT;
            nxt_prev  = QCC_HOLD;
          end else if (window_fault_in) begin
            nxt_state = QCC_HOLD;
          end else if (resume_done) begin
            nxt_state = QCC_QUICK;
            peak_clr  = 1'b1;
          end
        end
        QCC_INHIBIT: begin
          if (!stop_req) begin
            nxt_state = prev_ff;
            peak_clr  = 1'b1;
          end
        end
        QCC_FINISH: begin
          if (charge_hold_in) begin
            nxt_state = QCC_INHIBIT;
            nxt_prev  = QCC_FINISH;
          end
        end
        QCC_STANDBY: begin
          if (!above_standby_threshold_in) begin
            nxt_state = QCC_INIT;
          end
        end
        default: begin
          nxt_state = QCC_INIT;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= QCC_INIT;
      prev_ff  <= QCC_QUICK;
    end else begin
      state_ff <= nxt_state;
      prev_ff  <= nxt_prev;
    end
  end

  // timer select is taken as the charge mode is chosen
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sel_ff <= TSEL_LO;
    end else if (state_ff == QCC_INIT) begin
      sel_ff <= timer_select_in;
    end
  end

  // ==========================================================================
  // resume delay after the window comes back
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resume_cnt_ff <= '0;
    end else if (state_ff != QCC_RESUME || resume_done) begin
      resume_cnt_ff <= '0;
    end else begin
      resume_cnt_ff <= resume_cnt_ff + 1'b1;
    end
  end

  // ==========================================================================
  // cumulative quick charge time; it also serves the prohibit window
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      elapsed_ff <= '0;
    end else if (nxt_state == QCC_FINISH || nxt_state == QCC_STANDBY) begin
      elapsed_ff <= '0;
    end else if (state_ff == QCC_QUICK && sec_tick && !max_hit) begin
      elapsed_ff <= elapsed_ff + 1'b1;
    end
  end

  // ==========================================================================
  // stored peak of the mean
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      peak_ff <= '0;
    end else if (peak_clr || nxt_state == QCC_STANDBY) begin
      peak_ff <= '0;
    end else if (state_ff == QCC_QUICK && avg_vld && avg > peak_ff) begin
      peak_ff <= avg;
    end
  end

  // ==========================================================================
  // open-drain pins; the pin level is always low, only the enable moves
  assign charge_switch_n_o = 1'b0;
  assign status_lamp_n_o   = 1'b0;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      charge_switch_n_oe_n <= 1'b1;
    end else begin
      unique case (state_ff)
        QCC_QUICK, QCC_INIT, QCC_STANDBY: begin
          charge_switch_n_oe_n <= 1'b1;
        end
        default: begin
          charge_switch_n_oe_n <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      status_lamp_n_oe_n <= 1'b1;
    end else begin
      unique case (state_ff)
        QCC_QUICK: begin
          status_lamp_n_oe_n <= 1'b0;
        end
        QCC_HOLD, QCC_RESUME, QCC_INHIBIT: begin
          status_lamp_n_oe_n <= lamp_phase;
        end
        default: begin
          status_lamp_n_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================================
  // register bus, write side
  logic              aw_hold_ff;
  logic              w_hold_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [31:0]       w_data_ff;
  logic [3:0]        w_strb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              wr_go;

  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_hold_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign wr_go         = aw_hold_ff & w_hold_ff & ~bvalid_ff;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      w_hold_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_hold_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_ff <= 1'b1;
      unique case (aw_addr_ff)
        REG_CTRL, REG_STAT, REG_PEAK, REG_TIME: bresp_ff <= RESP_OKAY;
        default:                                bresp_ff <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // enable low acts as a software hold except in QCC_FINISH, which charge_hold_in leaves but enable low does not; restart bit is a one-shot
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_ff  <= CTRL_EN_RST;
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= 1'b0;
      if (wr_go && aw_addr_ff == REG_CTRL && w_strb_ff[0]) begin
        enable_ff  <= w_data_ff[CTRL_EN_BIT];
        restart_ff <= w_data_ff[CTRL_RST_BIT];
      end
    end
  end

  // ==========================================================================
  // register bus, read side
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] stat_word;

  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  always_comb begin
    stat_word = '0;
    stat_word[STAT_ST_LSB +: 3]  = state_ff;
    stat_word[STAT_HOLD_BIT]     = charge_hold_in;
    stat_word[STAT_FLT_BIT]      = window_fault_in;
    stat_word[STAT_ARM_BIT]      = armed;
    stat_word[STAT_SEL_LSB +: 2] = sel_ff;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CTRL: rdata_ff <= {31'h0, enable_ff};
        REG_STAT: rdata_ff <= stat_word;
        REG_PEAK: rdata_ff <= 32'(peak_ff);
        REG_TIME: rdata_ff <= 32'(elapsed_ff);
        default: begin
          rdata_ff <= '0;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

endmodule : qcc_core

/* tb/qcc_core_props.sv */
// concurrent checks on the quick charge controller core ports
`timescale 1ns/100ps
module qcc_core_props
  import qcc_pkg::*;
#(
  parameter int unsigned HALF_CYCLES = 4
) (
  input wire logic              clock,
  input wire logic              reset_n,
  input wire logic              window_fault_in,
  input wire logic              above_standby_threshold_in,
  input wire logic              charge_hold_in,
  input wire logic              charge_switch_n_o,
  input wire logic              charge_switch_n_oe_n,
  input wire logic              status_lamp_n_o,
  input wire logic              status_lamp_n_oe_n,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  a_pins_open_drain: assert property (!charge_switch_n_o && !status_lamp_n_o)
    else $error("open-drain level not low");
  a_hold_stops_charge: assert property (
    (charge_hold_in && !above_standby_threshold_in)[*3] |-> !charge_switch_n_oe_n)
    else $error("switch released during hold");
  a_fault_stops_charge: assert property (
    (window_fault_in && !above_standby_threshold_in)[*4] |-> !charge_switch_n_oe_n)
    else $error("switch released during fault");
  a_standby_releases: assert property (
    above_standby_threshold_in[*3] |-> charge_switch_n_oe_n && status_lamp_n_oe_n)
    else $error("pin driven in standby");
  // lamp phase free-runs, so any window of held hold sees whole half periods
  a_hold_lamp_pulse: assert property (
    (charge_hold_in && !above_standby_threshold_in)[*8]
    |-> status_lamp_n_oe_n != $past(status_lamp_n_oe_n, HALF_CYCLES))
    else $error("lamp not pulsing in hold");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_bresp_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_rresp_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read response dropped");
  a_unaligned_error: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr[1:0] != 2'h0 |=> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule : qcc_core_props

bind qcc_core qcc_core_props #(.HALF_CYCLES(HALF_CYCLES)) qcc_core_props_inst (.clock,
  .reset_n, .window_fault_in, .above_standby_threshold_in, .charge_hold_in,
  .charge_switch_n_o, .charge_switch_n_oe_n, .status_lamp_n_o, .status_lamp_n_oe_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

/* tb/qcc_cell_model.sv */
// behavioural cell: voltage creeps up while current flows
`timescale 1ns/100ps
module qcc_cell_model
  import qcc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sw_oe_n,
  input  wire logic       sw_o,
  input  wire logic       drop,
  output logic [V_W-1:0]  volts
);
  logic [V_W-1:0] v_ff = 12'h4b0;
  int             n_ff = 0;
  // pull-up on the switch line: released means current flows
  wire            charging = sw_oe_n ? 1'b1 : sw_o;
  always_ff @(posedge clock) begin
    n_ff <= n_ff + 1;
    if (charging && n_ff % 160 == 0) v_ff <= v_ff + 12'h1;
  end
  assign volts = drop ? v_ff - 12'h00a : v_ff;
endmodule : qcc_cell_model

/* tb/quick_charge_controller_tb.sv */
// self-checking bench of the quick charge controller core
`timescale 1ns/100ps
module quick_charge_controller_tb;
  import qcc_pkg::*;
  localparam int HC = 4;
  localparam int RC = 10;
  logic clock = 1'b0, reset_n = 1'b0, window_fault_in = 1'b0, drop = 1'b0;
  logic above_standby_threshold_in = 1'b0, charge_hold_in = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0] timer_select_in = 2'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, t, seed = 32'h76c4;
  logic [V_W-1:0] cell_voltage_in;
  logic charge_switch_n_o, charge_switch_n_oe_n, status_lamp_n_o, status_lamp_n_oe_n;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int bad_count = 0, n_compared = 0, cyc = 0;
  int lim = MAX_LO_MIN * 60 * 2 * HC;

  qcc_core #(.SAMPLE_CYCLES(20), .HALF_CYCLES(HC), .RESUME_CYCLES(RC)) qcc_core_inst (
    .clock, .reset_n, .cell_voltage_in, .window_fault_in, .above_standby_threshold_in,
    .charge_hold_in, .timer_select_in, .charge_switch_n_o, .charge_switch_n_oe_n,
    .status_lamp_n_o, .status_lamp_n_oe_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  qcc_cell_model qcc_cell_model_inst (.clock, .sw_oe_n(charge_switch_n_oe_n),
    .sw_o(charge_switch_n_o), .drop, .volts(cell_voltage_in));

  always #50 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      final_report();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask : wt
  // each channel is released only at the edge where its ready was seen
  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [3:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic cs(input logic [2:0] e);
    axr(REG_STAT);
    chk(32'(d[2:0]), 32'(e));
  endtask : cs

  // ==========================================================================
  // main sequence
  initial begin
    wt(6);
    reset_n <= 1'b1;
    wt(4);
    for (int i = 2; i >= 0; i--) begin
      timer_select_in <= 2'(i);
      axw(REG_CTRL, 32'h3);
      wt(3);
      axr(REG_STAT);
      chk(32'(d[9:8]), 32'(i));
      chk(32'(d[2:0]), 32'(QCC_QUICK));
    end
    axr(4'h2);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    seed = lfsr(seed);
    axw(REG_PEAK, seed);
    chk(32'(r), 32'(RESP_OKAY));
    axw(4'h6, seed);
    chk(32'(r), 32'(RESP_SLVERR));
    chk({charge_switch_n_oe_n, status_lamp_n_oe_n}, 32'h2);
    wt(200);
    axr(REG_PEAK);
    chk(32'(|d), 32'h1);
    charge_hold_in <= 1'b1;
    wt(6);
    cs(QCC_INHIBIT);
    charge_hold_in <= 1'b0;
    wt(3);
    cs(QCC_QUICK);
    axr(REG_PEAK);
    chk(d, 32'h0);
    wt(200);
    window_fault_in <= 1'b1;
    wt(3);
    cs(QCC_HOLD);
    axr(REG_TIME);
    t = d;
    wt(50);
    axr(REG_TIME);
    chk(d, t);
    window_fault_in <= 1'b0;
    wt(1);
    cs(QCC_RESUME);
    wt(RC);
    cs(QCC_QUICK);
    axr(REG_PEAK);
    chk(d, 32'h0);
    axw(REG_CTRL, 32'h0);
    cs(QCC_INHIBIT);
    axw(REG_CTRL, 32'h1);
    above_standby_threshold_in <= 1'b1;
    wt(3);
    cs(QCC_STANDBY);
    chk({charge_switch_n_oe_n, status_lamp_n_oe_n}, 32'h3);
    axr(REG_TIME);
    chk(d, 32'h0);
    above_standby_threshold_in <= 1'b0;
    wt(3);
    cs(QCC_QUICK);
    wt(2000);
    drop <= 1'b1;
    wt(400);
    cs(QCC_QUICK);
    drop <= 1'b0;
    wt(5600);
    drop <= 1'b1;
    wt(600);
    cs(QCC_FINISH);
    chk({charge_switch_n_oe_n, status_lamp_n_oe_n}, 32'h1);
    axr(REG_TIME);
    chk(d, 32'h0);
    drop <= 1'b0;
    axw(REG_CTRL, 32'h3);
    wt(lim - 400);
    cs(QCC_QUICK);
    wt(800);
    cs(QCC_FINISH);
    final_report();
  end
endmodule : quick_charge_controller_tb
